/* rtl/dpi_pkg.sv */
// Shared constants, types and state layouts for both ends of the potentiometer link
package dpi_pkg;

    // Timing: system clock and the link clock the controller generates
    localparam int SYS_PERIOD_NS  = 10;
    localparam int LINK_PERIOD_NS = 160;
    localparam int QTR_CYCLES     = LINK_PERIOD_NS / (4 * SYS_PERIOD_NS);
    localparam logic [3:0] QTR_LAST = 4'(QTR_CYCLES - 1);

    // Slave addresses selected by the strap pins {pin1, pin0}
    localparam logic [6:0] ADDR_STRAP_00 = 7'h18;
    localparam logic [6:0] ADDR_STRAP_10 = 7'h1a;
    localparam logic [6:0] ADDR_STRAP_01 = 7'h4c;
    localparam logic [6:0] ADDR_STRAP_11 = 7'h4e;
    localparam logic [1:0] STRAP_SETTLE  = 2'h2;

    // Command field of the instruction byte
    localparam logic [2:0] CMD_WIPER   = 3'h0;
    localparam logic [2:0] CMD_NVM     = 3'h1;
    localparam logic [2:0] CMD_WPROT   = 3'h2;
    localparam logic [2:0] CMD_NOP     = 3'h4;
    localparam logic [2:0] CMD_RESTORE = 3'h5;
    localparam logic [2:0] CMD_STORE   = 3'h6;

    // Tolerance locations and other fixed values
    localparam logic [4:0] TOL_LOC_HI  = 5'h1e;
    localparam logic [4:0] TOL_LOC_LO  = 5'h1f;
    localparam logic [7:0] MIDSCALE    = 8'h80;
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam logic [1:0] QTR_HIGH    = 2'h2;
    localparam logic [1:0] QTR_END     = 2'h3;

    typedef enum logic [2:0] {DS_IDLE, DS_ADDR, DS_INSTR, DS_WDATA, DS_RDATA, DS_WAIT} dpi_dev_st_type;
    typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BYTE, MS_STOP} dpi_mst_st_type;
    typedef enum logic [2:0] {SG_ADDRW, SG_INSTR, SG_DATA, SG_ADDRR, SG_READ} dpi_seg_type;

    typedef struct packed {
        logic           scl_s1, scl_s2, scl_s3;
        logic           sda_s1, sda_s2, sda_s3;
        logic [1:0]     strap_s1, strap_s2, strap_cnt;
        logic [6:0]     own_addr;
        dpi_dev_st_type st;
        logic [3:0]     bitcnt;
        logic           ack_phase;
        logic [7:0]     shreg;
        logic           sda_low;
        logic [2:0]     cmd;
        logic [4:0]     ptr;
        logic [7:0]     wiper, nvm;
        logic           wprot;
    } dpi_dev_state_type;

    localparam dpi_dev_state_type DPI_DEV_RST = '{scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
        sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1, strap_s1: 2'h0, strap_s2: 2'h0, strap_cnt: 2'h0,
        own_addr: ADDR_STRAP_00, st: DS_IDLE, bitcnt: 4'h0, ack_phase: 1'b0, shreg: 8'h00,
        sda_low: 1'b0, cmd: CMD_WIPER, ptr: 5'h00, wiper: MIDSCALE, nvm: MIDSCALE, wprot: 1'b0};

    typedef struct packed {
        logic           sda_s1, sda_s2;
        dpi_mst_st_type st;
        dpi_seg_type    seg;
        logic [3:0]     divcnt;
        logic [1:0]     qtr;
        logic [3:0]     bitcnt;
        logic [7:0]     shreg;
        logic           scl_lvl, sda_lvl;
        logic [6:0]     addr;
        logic [7:0]     instr, data;
        logic           w_data, rd;
        logic [1:0]     rd_left;
        logic [15:0]    rd_data;
        logic           nack, done;
    } dpi_mst_state_type;

    localparam dpi_mst_state_type DPI_MST_RST = '{sda_s1: 1'b1, sda_s2: 1'b1, st: MS_IDLE,
        seg: SG_ADDRW, divcnt: 4'h0, qtr: 2'h0, bitcnt: 4'h0, shreg: 8'h00, scl_lvl: 1'b1,
        sda_lvl: 1'b1, addr: 7'h00, instr: 8'h00, data: 8'h00, w_data: 1'b0, rd: 1'b0,
        rd_left: 2'h0, rd_data: 16'h0000, nack: 1'b0, done: 1'b0};

endpackage

/* rtl/dpi_if.sv */
// Two-wire link between controller and potentiometer, with open-drain resolution
`timescale 1ns/1ns
`default_nettype none
interface dpi_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic scl;
    logic sda;

    // Pull-up wins unless an enabled driver pulls low
    assign scl = ~(m_scl_oe & ~m_scl_o);
    assign sda = ~(m_sda_oe & ~m_sda_o) & ~(d_sda_oe & ~d_sda_o);

    modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe, input scl, input sda);
    modport device (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

/* rtl/dpi_device.sv */
// Potentiometer end: serial command slave, wiper, nonvolatile copy and write protect
//
// How it works
// - Data falling while clock high starts.
// - First byte: 7-bit address, direction bit.
// - Straps sampled once, mapped to address.
// - Matching address acked; others wait for next start or stop.
// - Second written byte is instruction, acked.
// - Decode wiper, EEPROM, protect, nop, restore, store.
// - Data byte MSB first, acked.
// - Protect command uses only data bit 0.
// - Power-up leaves protection off.
// - Store and restore need no data.
// - Read after address, instruction, repeated start.
// - Read bits change on falling clock.
// - Data rising while clock high stops.
// - Master ends reads with no-ack, stop.
// - Every further wiper byte updates wiper unless protected.
// - Wiper may be read repeatedly.
// - Tolerance bytes readable singly or consecutively.
// - Pointer advances from high to low tolerance.
// - Selection survives transaction for direct reads.
// - Wiper loads midscale copy at power-up.
`timescale 1ns/1ns
`default_nettype none
module dpi_device
    import dpi_pkg::*;
#(
    parameter logic [7:0] TOL_SIGN_INT = 8'h00,
    parameter logic [7:0] TOL_FRACTION = 8'h00
)
(
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    dpi_if.device           link,
    input  wire logic       addr_strap_pin0,
    input  wire logic       addr_strap_pin1,
    output logic [7:0]      wiper_setting_register,
    output logic [7:0]      wiper_nv_copy,
    output logic            write_protect_active
);

    dpi_dev_state_type s_r;
    dpi_dev_state_type s_nxt;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_cond;
    logic              stop_cond;
    logic [7:0]        rd_byte;

    // Edges use only the second and third stages, never the first
    assign scl_rise   = s_r.scl_s2 & ~s_r.scl_s3;
    assign scl_fall   = ~s_r.scl_s2 & s_r.scl_s3;
    assign start_cond = s_r.scl_s2 & s_r.scl_s3 & ~s_r.sda_s2 & s_r.sda_s3;
    assign stop_cond  = s_r.scl_s2 & s_r.scl_s3 & s_r.sda_s2 & ~s_r.sda_s3;

    // Byte returned on a read, chosen by the kept command and pointer
    always_comb
    begin
        rd_byte = s_r.wiper;
        if (s_r.cmd == CMD_NVM)
        begin
            if (s_r.ptr == TOL_LOC_HI)
                rd_byte = TOL_SIGN_INT;
            else if (s_r.ptr == TOL_LOC_LO)
                rd_byte = TOL_FRACTION;
            else
                rd_byte = s_r.nvm;
        end
    end

    // Whole next state
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.scl_s1   = link.scl;
        s_nxt.scl_s2   = s_r.scl_s1;
        s_nxt.scl_s3   = s_r.scl_s2;
        s_nxt.sda_s1   = link.sda;
        s_nxt.sda_s2   = s_r.sda_s1;
        s_nxt.sda_s3   = s_r.sda_s2;
        s_nxt.strap_s1 = {addr_strap_pin1, addr_strap_pin0};
        s_nxt.strap_s2 = s_r.strap_s1;

        // straps taken once the synchroniser has filled, then frozen
        if (s_r.strap_cnt != STRAP_SETTLE + 2'h1)
        begin
            s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
            if (s_r.strap_cnt == STRAP_SETTLE)
            begin
                case (s_r.strap_s2)
                    2'b00:   s_nxt.own_addr = ADDR_STRAP_00;
                    2'b10:   s_nxt.own_addr = ADDR_STRAP_10;
                    2'b01:   s_nxt.own_addr = ADDR_STRAP_01;
                    default: s_nxt.own_addr = ADDR_STRAP_11;
                endcase
            end
        end

        if (start_cond)
        begin
            // start or repeated start reopens address phase
            s_nxt.st        = DS_ADDR;
            s_nxt.bitcnt    = 4'h0;
            s_nxt.ack_phase = 1'b0;
            s_nxt.sda_low   = 1'b0;
        end
        else if (stop_cond)
        begin
            // back to idle; command and pointer are kept
            s_nxt.st        = DS_IDLE;
            s_nxt.ack_phase = 1'b0;
            s_nxt.sda_low   = 1'b0;
        end
        else if (scl_rise && s_r.st != DS_IDLE && s_r.st != DS_WAIT)
        begin
            if (!s_r.ack_phase)
            begin
                s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                if (s_r.st != DS_RDATA)
                    s_nxt.shreg = {s_r.shreg[6:0], s_r.sda_s2};
            end
            else if (s_r.st == DS_RDATA)
            begin
                // no-ack from master ends the read burst
                if (s_r.sda_s2)
                    s_nxt.st = DS_WAIT;
                // consecutive tolerance read advances pointer
                // Own address ack still pulls low, so it must not count as a master ack
                else if (!s_r.sda_low && s_r.cmd == CMD_NVM && s_r.ptr == TOL_LOC_HI)
                    s_nxt.ptr = TOL_LOC_LO;
            end
        end
        else if (scl_fall && s_r.st != DS_IDLE)
        begin
            if (s_r.ack_phase)
            begin
                // Ninth clock over: release and start next byte
                s_nxt.ack_phase = 1'b0;
                s_nxt.bitcnt    = 4'h0;
                s_nxt.sda_low   = 1'b0;
                if (s_r.st == DS_RDATA)
                begin
                    // read byte reloaded for every repeated read
                    s_nxt.shreg   = rd_byte;
                    // first read bit placed on the falling edge
                    s_nxt.sda_low = ~rd_byte[7];
                end
            end
            else if (s_r.bitcnt == BYTE_BITS && s_r.st != DS_WAIT)
            begin
                s_nxt.ack_phase = 1'b1;
                s_nxt.sda_low   = 1'b1;
                case (s_r.st)
                    DS_ADDR:
                    begin
                        // ack own address, otherwise wait in DS_WAIT for the next start or stop
                        if (s_r.shreg[7:1] == s_r.own_addr)
                            // direction bit picks read or write
                            s_nxt.st = s_r.shreg[0] ? DS_RDATA : DS_INSTR;
                        else
                        begin
                            s_nxt.st        = DS_WAIT;
                            s_nxt.ack_phase = 1'b0;
                            s_nxt.sda_low   = 1'b0;
                        end
                    end
                    DS_INSTR:
                    begin
                        s_nxt.st  = DS_WDATA;
                        s_nxt.cmd = s_r.shreg[7:5];
                        s_nxt.ptr = s_r.shreg[4:0];
                        // store and restore act on the instruction
                        // no data byte needed for them
                        if (s_r.shreg[7:5] == CMD_RESTORE && !s_r.wprot)
                            s_nxt.wiper = s_r.nvm;
                        else if (s_r.shreg[7:5] == CMD_STORE && !s_r.wprot)
                            s_nxt.nvm = s_r.wiper;
                    end
                    DS_WDATA:
                    begin
                        // data byte steered by the command
                        // each further wiper byte rewrites the wiper while protection is off
                        case (s_r.cmd)
                            CMD_WIPER: if (!s_r.wprot) s_nxt.wiper = s_r.shreg;
                            CMD_NVM:   if (!s_r.wprot) s_nxt.nvm = s_r.shreg;
                            // only bit 0 sets or clears protection
                            CMD_WPROT: s_nxt.wprot = s_r.shreg[0];
                            default:   s_nxt.wprot = s_r.wprot;
                        endcase
                    end
                    DS_RDATA:
                        // release the line for the master's answer
                        s_nxt.sda_low = 1'b0;
                    default:
                        s_nxt.sda_low = 1'b0;
                endcase
            end
            else if (s_r.st == DS_RDATA && s_r.bitcnt != 4'h0)
            begin
                // next read bit on each falling edge
                s_nxt.shreg   = {s_r.shreg[6:0], 1'b0};
                s_nxt.sda_low = ~s_r.shreg[6];
            end
        end
    end

    // Single register; power-up clears protection and loads midscale
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            // protection off; wiper from midscale copy
            s_r <= DPI_DEV_RST;
        else
            s_r <= s_nxt;
    end

    // Open-drain data: only ever pulls low
    assign link.d_sda_o         = 1'b0;
    assign link.d_sda_oe        = s_r.sda_low;
    assign wiper_setting_register = s_r.wiper;
    assign wiper_nv_copy        = s_r.nvm;
    assign write_protect_active = s_r.wprot;

endmodule
`default_nettype wire

/* rtl/dpi_master.sv */
// Controller end: runs one link transaction per request, generating the clock by division
`timescale 1ns/1ns
`default_nettype none
module dpi_master
    import dpi_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    dpi_if.master           link,
    input  wire logic       req_valid,
    input  wire logic [6:0] req_addr,
    input  wire logic [7:0] req_instr,
    input  wire logic [7:0] req_data,
    input  wire logic       req_write_instr,
    input  wire logic       req_write_data,
    input  wire logic       req_read,
    input  wire logic [1:0] req_read_count,
    output logic            busy,
    output logic            done,
    output logic            nack,
    output logic [15:0]     rd_data
);

    dpi_mst_state_type s_r;
    dpi_mst_state_type s_nxt;
    logic              qtr_tick;
    logic              sym_end;

    assign qtr_tick = (s_r.st != MS_IDLE) && (s_r.divcnt == QTR_LAST);
    assign sym_end  = qtr_tick && (s_r.qtr == QTR_END);

    always_comb
    begin
        s_nxt        = s_r;
        s_nxt.sda_s1 = link.sda;
        s_nxt.sda_s2 = s_r.sda_s1;
        s_nxt.done   = 1'b0;
        if (s_r.st != MS_IDLE)
        begin
            s_nxt.divcnt = qtr_tick ? 4'h0 : s_r.divcnt + 4'h1;
            if (qtr_tick)
                s_nxt.qtr = s_r.qtr + 2'h1;
        end

        case (s_r.st)
            MS_IDLE:
            begin
                if (req_valid)
                begin
                    // every transaction opens with a start
                    s_nxt.st      = MS_START;
                    s_nxt.qtr     = 2'h0;
                    s_nxt.divcnt  = 4'h0;
                    s_nxt.addr    = req_addr;
                    s_nxt.instr   = req_instr;
                    s_nxt.data    = req_data;
                    s_nxt.w_data  = req_write_data;
                    s_nxt.rd      = req_read;
                    s_nxt.rd_left = req_read_count;
                    s_nxt.nack    = 1'b0;
                    // without instruction, go straight to a read address
                    s_nxt.seg     = req_write_instr ? SG_ADDRW : SG_ADDRR;
                    s_nxt.shreg   = {req_addr, ~req_write_instr};
                end
            end
            MS_START:
            begin
                if (sym_end)
                begin
                    s_nxt.st     = MS_BYTE;
                    s_nxt.bitcnt = 4'h0;
                end
            end
            MS_BYTE:
            begin
                if (sym_end)
                begin
                    s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                    if (s_r.bitcnt != BYTE_BITS)
                        // Shift samples reads; for writes it advances the next bit
                        s_nxt.shreg = {s_r.shreg[6:0], s_r.sda_s2};
                    else
                    begin
                        s_nxt.bitcnt = 4'h0;
                        s_nxt.st     = MS_STOP;
                        if (s_r.seg == SG_READ)
                        begin
                            s_nxt.rd_data = {s_r.rd_data[7:0], s_r.shreg};
                            s_nxt.rd_left = s_r.rd_left - 2'h1;
                            // more reads continue in the same burst
                            if (s_r.rd_left > 2'h1)
                                s_nxt.st = MS_BYTE;
                        end
                        else if (s_r.sda_s2)
                            // Missing slave acknowledge aborts with a stop
                            s_nxt.nack = 1'b1;
                        else
                        begin
                            s_nxt.st = MS_BYTE;
                            case (s_r.seg)
                                SG_ADDRW:
                                begin
                                    s_nxt.seg   = SG_INSTR;
                                    s_nxt.shreg = s_r.instr;
                                end
                                SG_ADDRR:
                                    s_nxt.seg = SG_READ;
                                default:
                                begin
                                    if (s_r.seg == SG_INSTR && s_r.w_data)
                                    begin
                                        s_nxt.seg   = SG_DATA;
                                        s_nxt.shreg = s_r.data;
                                    end
                                    else if (s_r.rd)
                                    begin
                                        s_nxt.st    = MS_START;
                                        s_nxt.seg   = SG_ADDRR;
                                        s_nxt.shreg = {s_r.addr, 1'b1};
                                    end
                                    else
                                        s_nxt.st = MS_STOP;
                                end
                            endcase
                        end
                    end
                end
            end
            MS_STOP:
            begin
                if (sym_end)
                begin
                    s_nxt.st   = MS_IDLE;
                    s_nxt.done = 1'b1;
                end
            end
            default:
                s_nxt.st = MS_IDLE;
        endcase

        // Pin levels for the coming cycle, held in flip-flops
        case (s_nxt.st)
            MS_START:
            begin
                s_nxt.scl_lvl = (s_nxt.qtr != 2'h0);
                s_nxt.sda_lvl = (s_nxt.qtr < QTR_HIGH);
            end
            MS_STOP:
            begin
                // data low before clock rises, then raised for stop
                s_nxt.scl_lvl = (s_nxt.qtr != 2'h0);
                s_nxt.sda_lvl = (s_nxt.qtr >= QTR_HIGH);
            end
            MS_BYTE:
            begin
                s_nxt.scl_lvl = (s_nxt.qtr >= QTR_HIGH);
                if (s_nxt.bitcnt != BYTE_BITS)
                    s_nxt.sda_lvl = (s_nxt.seg == SG_READ) ? 1'b1 : s_nxt.shreg[7];
                else
                    // no-ack on the last read byte, ack before it
                    s_nxt.sda_lvl = (s_nxt.seg == SG_READ) ? (s_nxt.rd_left == 2'h1) : 1'b1;
            end
            default:
            begin
                s_nxt.scl_lvl = 1'b1;
                s_nxt.sda_lvl = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            s_r <= DPI_MST_RST;
        else
            s_r <= s_nxt;
    end

    // Both lines open drain; enable means pulling low
    assign link.m_scl_o  = 1'b0;
    assign link.m_scl_oe = ~s_r.scl_lvl;
    assign link.m_sda_o  = 1'b0;
    assign link.m_sda_oe = ~s_r.sda_lvl;
    assign busy          = (s_r.st != MS_IDLE);
    assign done          = s_r.done;
    assign nack          = s_r.nack;
    assign rd_data       = s_r.rd_data;

endmodule
`default_nettype wire

/* tb/dpi_props.sv */
// Concurrent checks on the shared two-wire link
`timescale 1ns/1ns
`default_nettype none
module dpi_props
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic m_scl_o,
    input wire logic m_scl_oe,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic d_sda_o,
    input wire logic d_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // Open drain only: a driven high would fight the pull-up
    odrain_level_a:
        assert property (!m_scl_o && !m_sda_o && !d_sda_o) else $error("link driven high");
    read_edge_a:
        assert property ($changed(d_sda_oe) |-> !scl && !$past(scl)) else $error("device moved sda with scl high");
    ack_hold_a:
        assert property ($rose(d_sda_oe) |-> d_sda_oe [*8]) else $error("device low pulse too short");
    ack_release_a:
        assert property ($rose(d_sda_oe) |-> ##[9:300] !d_sda_oe) else $error("device never released sda");
    start_clear_a:
        assert property ($fell(sda) && scl |-> !d_sda_oe) else $error("device caused a start");
    stop_idle_a:
        assert property ($rose(sda) && scl |=> !d_sda_oe [*8]) else $error("device busy after stop");
    scl_high_a:
        assert property ($rose(scl) |-> scl [*6]) else $error("clock high phase too short");
    // Checked inside reset, so the usual disable is lifted
    reset_quiet_a:
        assert property (disable iff (1'b0) sys_rst |=> !d_sda_oe && !m_sda_oe && !m_scl_oe)
            else $error("link not released in reset");
endmodule
`default_nettype wire

/* tb/test_digipot_i2c_command_slave.sv */
// Self-checking bench joining controller and potentiometer ends
`timescale 1ns/1ns
`default_nettype none
module test_digipot_i2c_command_slave;
    import dpi_pkg::*;
    localparam logic [7:0] TOL_A = 8'h1c;
    localparam logic [7:0] TOL_B = 8'h0f;
    // Request flags {write instr, write data, read}
    localparam logic [2:0] WR = 3'h6, SEL = 3'h4, RDI = 3'h5, RDO = 3'h1;
    logic        clk_sys   = 1'b0;
    logic        sys_rst   = 1'b1;
    logic [1:0]  strap     = 2'h0;
    logic        req_valid = 1'b0;
    logic [6:0]  req_addr  = 7'h00;
    logic [7:0]  req_instr = 8'h00;
    logic [7:0]  req_data  = 8'h00;
    logic [2:0]  req_flags = 3'h0;
    logic [1:0]  req_cnt   = 2'h1;
    logic        busy, done, nack, wprot;
    logic [15:0] rd_data;
    logic [7:0]  wiper, nvcopy, v, w;
    logic [6:0]  own;
    logic [2:0]  odd [3] = '{CMD_NOP, 3'h3, 3'h7};
    int          fails   = 0;
    int          n_tests = 0;

    dpi_if u_dpi_if ();
    dpi_device #(.TOL_SIGN_INT(TOL_A), .TOL_FRACTION(TOL_B)) u_dpi_device (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .link(u_dpi_if.device), .addr_strap_pin0(strap[0]), .addr_strap_pin1(strap[1]),
        .wiper_setting_register(wiper), .wiper_nv_copy(nvcopy), .write_protect_active(wprot));
    dpi_master u_dpi_master (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(u_dpi_if.master), .req_valid(req_valid),
        .req_addr(req_addr), .req_instr(req_instr), .req_data(req_data), .req_write_instr(req_flags[2]),
        .req_write_data(req_flags[1]), .req_read(req_flags[0]), .req_read_count(req_cnt), .busy(busy),
        .done(done), .nack(nack), .rd_data(rd_data));
    dpi_props u_dpi_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .m_scl_o(u_dpi_if.m_scl_o),
        .m_scl_oe(u_dpi_if.m_scl_oe), .m_sda_o(u_dpi_if.m_sda_o), .m_sda_oe(u_dpi_if.m_sda_oe),
        .d_sda_o(u_dpi_if.d_sda_o), .d_sda_oe(u_dpi_if.d_sda_oe), .scl(u_dpi_if.scl), .sda(u_dpi_if.sda));

    always #5 clk_sys = ~clk_sys;

    task automatic end_sim();
        $display("Counts: %0d compared, %0d mismatched", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Straps must be steady until the device latches them
    task automatic rst_with(input logic [1:0] s);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        strap   <= s;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask

    // One transaction; done is looked at mid-cycle to avoid the edge race
    task automatic xfer(input logic [6:0] a, input logic [2:0] c, input logic [4:0] p, input logic [7:0] d,
        input logic [2:0] f, input logic [1:0] n);
        int k;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_addr  <= a;
        req_instr <= {c, p};
        req_data  <= d;
        req_flags <= f;
        req_cnt   <= n;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        @(negedge clk_sys);
        chk("busy", 16'(busy), 16'h1);
        for (k = 0; k < 2000 && done !== 1'b1; k++)
            @(negedge clk_sys);
        chk("transfer done", 16'(done), 16'h1);
    endtask

    function automatic logic [6:0] addr_of(input logic [1:0] s);
        case (s)
            2'h0: return ADDR_STRAP_00;
            2'h1: return ADDR_STRAP_01;
            2'h2: return ADDR_STRAP_10;
            default: return ADDR_STRAP_11;
        endcase
    endfunction

    initial
    begin
        void'($urandom(12874));
        for (int s = 0; s < 4; s++)
        begin
            rst_with(2'(s));
            own = addr_of(2'(s));
            chk("power-up wiper", 16'(wiper), 16'(MIDSCALE));
            chk("power-up protect", 16'(wprot), 16'h0);
            xfer(own ^ 7'h02, CMD_WIPER, 5'h0, 8'h11, WR, 2'h1);
            chk("foreign nack", 16'(nack), 16'h1);
            chk("foreign ignored", 16'(wiper), 16'(MIDSCALE));
            xfer(own, CMD_WIPER, 5'h0, 8'h00, RDI, 2'h1);
            chk("own address acked", 16'(nack), 16'h0);
            chk("power-up read", 16'(rd_data[7:0]), 16'(MIDSCALE));
            $display("Strap test %0d done", s);
        end
        v = 8'($urandom);
        w = ~v;
        xfer(own, CMD_WIPER, 5'h0, v, WR, 2'h1);
        chk("write acked", 16'(nack), 16'h0);
        chk("wiper write", 16'(wiper), 16'(v));
        xfer(own, CMD_WIPER, 5'h0, 8'h00, RDI, 2'h1);
        chk("wiper read", 16'(rd_data[7:0]), 16'(v));
        xfer(own, CMD_WIPER, 5'h0, 8'h00, RDO, 2'h2);
        chk("wiper repeated read", rd_data, {v, v});
        xfer(own, CMD_NVM, 5'h0, w, WR, 2'h1);
        chk("copy write", 16'(nvcopy), 16'(w));
        xfer(own, CMD_NVM, 5'h0, 8'h00, RDO, 2'h1);
        chk("copy direct read", 16'(rd_data[7:0]), 16'(w));
        xfer(own, CMD_RESTORE, 5'h0, 8'h00, SEL, 2'h1);
        chk("restore", 16'(wiper), 16'(w));
        xfer(own, CMD_WIPER, 5'h0, v, WR, 2'h1);
        xfer(own, CMD_STORE, 5'h0, 8'h00, SEL, 2'h1);
        chk("store", 16'(nvcopy), 16'(v));
        xfer(own, CMD_NVM, TOL_LOC_HI, 8'h00, RDI, 2'h2);
        chk("tolerance pair", rd_data, {TOL_A, TOL_B});
        xfer(own, CMD_NVM, TOL_LOC_LO, 8'h00, RDI, 2'h1);
        chk("tolerance single", 16'(rd_data[7:0]), 16'(TOL_B));
        $display("Data path test done");
        xfer(own, CMD_WPROT, 5'h0, 8'h01, WR, 2'h1);
        chk("protect on", 16'(wprot), 16'h1);
        xfer(own, CMD_WIPER, 5'h0, w, WR, 2'h1);
        xfer(own, CMD_STORE, 5'h0, 8'h00, SEL, 2'h1);
        chk("protected wiper", 16'(wiper), 16'(v));
        chk("protected copy", 16'(nvcopy), 16'(v));
        xfer(own, CMD_WPROT, 5'h0, 8'h00, WR, 2'h1);
        chk("protect off", 16'(wprot), 16'h0);
        foreach (odd[i])
        begin
            xfer(own, odd[i], 5'h0, w, WR, 2'h1);
            chk("ignored command", 16'(wiper), 16'(v));
            chk("ignored command acked", 16'(nack), 16'h0);
        end
        $display("Command test done");
        end_sim();
    end

    // Bound well above twenty-five transactions of under a thousand cycles
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        fails++;
        end_sim();
    end
endmodule
`default_nettype wire
